// [ftim_pkg.sv]
// Package: constants and types for the fastening timer and input map block
// How it works
// - Valve close timer starts at judge wait expiry; valve drops on its expiry.
// - Reverse done timer ends reverse operation only in fastening mode 9.
// - Pin alignment timer starts at torque judgment; measurement held until expiry.
// - Pin alignment value 0 means no pause after judgment.
// - Pace control timer counts seconds, used only when pace select is 2 or 3.
// - Year field 0 to 255 is an offset from year 2000.
// - Month and day arrive as one decimal value 0101 to 1231.
// - Hour and minute arrive as one decimal value 0000 to 2359.
// - Five input terminals, each mapped to a function code by configuration.
// - Code 1 is judgment trigger at select 0, process start at 1 or 2.
// - Code 2 is external start for continuous tools.
// - Code 3 reloads remaining count from the total, or clears only the error while one is active.
// - Code 4 is the second judgment trigger at pace select 1.
// - Code 5 forces count-good even with fasteners remaining.
// - Code 6 click wrench pulses each decrement the remaining count, down to zero.
// - Codes 7 to 9 are encoded program select lines at scheme 0.
// - Codes 10 to 14 are one-per-program lines at scheme 1.
// - Code 15 stops the tool externally.
// - A map with one code on two terminals is refused.
// - Five output terminals, each mapped to an output function.
// - Judge wait timer starts at fastening done; judgment output waits for it.
package ftim_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int TICK_MS_CYCLES = CLK_HZ / 1000;
    localparam int TIME_W = 14;
    localparam int NUM_IN = 5;
    localparam int NUM_OUT = 5;
    localparam int CODE_W = 5;
    localparam logic [TIME_W-1:0] JUDGE_WAIT_DEF = 14'd300;
    localparam logic [TIME_W-1:0] VALVE_CLOSE_DEF = 14'd300;
    localparam logic [TIME_W-1:0] REVERSE_DONE_DEF = 14'd300;
    localparam logic [TIME_W-1:0] PIN_ALIGN_DEF = 14'd0;
    localparam logic [TIME_W-1:0] PACE_DEF = 14'd100;
    localparam logic [TIME_W-1:0] TIME_MAX = 14'd9999;
    localparam logic [TIME_W-1:0] JUDGE_WAIT_MIN = 14'd100;
    localparam logic [3:0] FMODE_REVERSE = 4'h9;
    localparam logic [1:0] PACE_JUDGE = 2'h0;
    localparam logic [1:0] PACE_TWO = 2'h1;
    localparam logic [1:0] PACE_TIME_A = 2'h2;
    localparam logic [1:0] PACE_TIME_B = 2'h3;
    localparam logic [11:0] YEAR_BASE = 12'd2000;
    localparam logic [10:0] MD_MIN = 11'd101;
    localparam logic [10:0] MD_MAX = 11'd1231;
    localparam logic [11:0] HM_MAX = 12'd2359;
    localparam logic [15:0] REMAIN_DEF = 16'd1;
    // Function codes
    localparam logic [CODE_W-1:0] FN_JUDGE1 = 5'h01;
    localparam logic [CODE_W-1:0] FN_START = 5'h02;
    localparam logic [CODE_W-1:0] FN_RESET = 5'h03;
    localparam logic [CODE_W-1:0] FN_JUDGE2 = 5'h04;
    localparam logic [CODE_W-1:0] FN_FORCE = 5'h05;
    localparam logic [CODE_W-1:0] FN_CLICK = 5'h06;
    localparam logic [CODE_W-1:0] FN_PROG_A = 5'h07;
    localparam logic [CODE_W-1:0] FN_PROG_1 = 5'h0A;
    localparam logic [CODE_W-1:0] FN_STOP = 5'h0F;
    localparam int NUM_FN = 16;
    localparam int NUM_OFN = 19;
    localparam logic [CODE_W*NUM_IN-1:0] IN_MAP_DEF = {5'h08, 5'h07, 5'h03, 5'h02, 5'h01};
    localparam logic [CODE_W*NUM_OUT-1:0] OUT_MAP_DEF = {5'h05, 5'h04, 5'h03, 5'h02, 5'h01};
    typedef enum logic [2:0] {FTIM_IDLE, FTIM_WAIT, FTIM_VALVE, FTIM_REV, FTIM_PIN} ftim_state_e;
endpackage

// [ftim_tick_if.sv]
// Interface: shared timing ticks between the top and its timers
`timescale 1ns/1ps
`default_nettype none
interface ftim_tick_if;
    logic tick_ms;
    logic tick_s;
    modport src (output tick_ms, output tick_s);
    modport dst (input tick_ms, input tick_s);
endinterface
`default_nettype wire

// [ftim_ticker.sv]
// Tick generator: 1 ms and 1 s pulses from the system clock
`timescale 1ns/1ps
`default_nettype none
module ftim_ticker
    import ftim_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    ftim_tick_if.src ticks
);
    logic [13:0] ms_cnt_reg;
    logic [9:0] s_cnt_reg;
    // Millisecond divider, one-cycle tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt_reg <= 14'h0000;
            ticks.tick_ms <= 1'b0;
        end else begin
            ticks.tick_ms <= (ms_cnt_reg == 14'(TICK_MS_CYCLES - 1));
            ms_cnt_reg <= (ms_cnt_reg == 14'(TICK_MS_CYCLES - 1)) ? 14'h0000 : ms_cnt_reg + 14'h0001;
        end
    end
    // Second divider counts millisecond ticks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_cnt_reg <= 10'h000;
            ticks.tick_s <= 1'b0;
        end else begin
            ticks.tick_s <= ticks.tick_ms && (s_cnt_reg == 10'(MS_PER_S - 1));
            if (ticks.tick_ms) begin
                s_cnt_reg <= (s_cnt_reg == 10'(MS_PER_S - 1)) ? 10'h000 : s_cnt_reg + 10'h001;
            end
        end
    end
endmodule
`default_nettype wire

// [ftim_timer.sv]
// One-shot down counter with a single-cycle expiry pulse
`timescale 1ns/1ps
`default_nettype none
module ftim_timer
    import ftim_pkg::*;
#(
    parameter bit USE_SEC = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    ftim_tick_if.dst ticks,
    input wire logic start,
    input wire logic abort,
    input wire logic [TIME_W-1:0] preset,
    output logic running,
    output logic expired
);
    logic [TIME_W-1:0] cnt_reg;
    logic tick;
    assign tick = USE_SEC ? ticks.tick_s : ticks.tick_ms;
    // Count down on ticks; zero preset expires at once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (abort) begin
                running <= 1'b0;
            end else if (start) begin
                cnt_reg <= preset;
                running <= (preset != '0);
                expired <= (preset == '0);
            end else if (running && tick) begin
                cnt_reg <= cnt_reg - 1'b1;
                if (cnt_reg == {{(TIME_W-1){1'b0}}, 1'b1}) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [ftim_core.sv]
// Top: sequencing timers, calendar load and input/output terminal mapping
`timescale 1ns/1ps
`default_nettype none
module ftim_core
    import ftim_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ftim_pkg::TIME_W-1:0] judge_wait_ms,
    input wire logic [ftim_pkg::TIME_W-1:0] valve_close_ms,
    input wire logic [ftim_pkg::TIME_W-1:0] reverse_done_ms,
    input wire logic [ftim_pkg::TIME_W-1:0] pin_align_ms,
    input wire logic [ftim_pkg::TIME_W-1:0] pace_timer_s,
    input wire logic [3:0] fastening_mode,
    input wire logic [1:0] pace_control_select,
    input wire logic program_select_scheme,
    input wire logic fastening_done,
    input wire logic torque_judged,
    input wire logic pace_start,
    input wire logic error_active,
    input wire logic [15:0] fastener_total,
    input wire logic [7:0] year_in,
    input wire logic [10:0] month_day_in,
    input wire logic [11:0] hour_min_in,
    input wire logic cal_load,
    input wire logic [ftim_pkg::CODE_W*ftim_pkg::NUM_IN-1:0] in_map,
    input wire logic map_load,
    input wire logic [ftim_pkg::NUM_IN-1:0] in_pins,
    input wire logic [ftim_pkg::CODE_W*ftim_pkg::NUM_OUT-1:0] out_map,
    input wire logic [ftim_pkg::NUM_OFN-1:0] out_functions,
    output logic [ftim_pkg::NUM_OUT-1:0] out_pins,
    output logic valve_on,
    output logic reverse_end,
    output logic measure_hold,
    output logic judge_out,
    output logic pace_expired,
    output logic map_refused,
    output logic cal_refused,
    output logic [11:0] cal_year,
    output logic [3:0] cal_month,
    output logic [4:0] cal_day,
    output logic [4:0] cal_hour,
    output logic [5:0] cal_minute,
    output logic judge_trigger,
    output logic process_start,
    output logic ext_start,
    output logic error_clear,
    output logic force_count_good,
    output logic [15:0] remaining,
    output logic [2:0] program_no,
    output logic tool_stop
);
    ////////////////////////////////////////////////////////////////////////
    ftim_tick_if ticks ();
    ftim_ticker u_ticker (.clk(clk), .rst_n(rst_n), .ticks(ticks));

    ftim_state_e state_reg;
    logic judge_exp, valve_exp, rev_exp, pin_exp, pace_exp;
    logic judge_run, valve_run, rev_run, pin_run, pace_run;
    logic [TIME_W-1:0] jw_preset;

    // Clamp judge wait into its legal span
    always_comb begin
        jw_preset = judge_wait_ms;
        if (judge_wait_ms < JUDGE_WAIT_MIN) begin
            jw_preset = JUDGE_WAIT_MIN;
        end else if (judge_wait_ms > TIME_MAX) begin
            jw_preset = TIME_MAX;
        end
    end

    ftim_timer u_judge (.clk(clk), .rst_n(rst_n), .ticks(ticks), .start(fastening_done && state_reg == FTIM_IDLE),
        .abort(1'b0), .preset(jw_preset), .running(judge_run), .expired(judge_exp));
    ftim_timer u_valve (.clk(clk), .rst_n(rst_n), .ticks(ticks), .start(judge_exp), .abort(1'b0),
        .preset(valve_close_ms == '0 ? {{(TIME_W-1){1'b0}}, 1'b1} : valve_close_ms),
        .running(valve_run), .expired(valve_exp));
    ftim_timer u_rev (.clk(clk), .rst_n(rst_n), .ticks(ticks),
        .start(valve_exp && fastening_mode == FMODE_REVERSE), .abort(1'b0),
        .preset(reverse_done_ms), .running(rev_run), .expired(rev_exp));
    ftim_timer u_pin (.clk(clk), .rst_n(rst_n), .ticks(ticks), .start(torque_judged), .abort(1'b0),
        .preset(pin_align_ms), .running(pin_run), .expired(pin_exp));
    ftim_timer #(.USE_SEC(1'b1)) u_pace (.clk(clk), .rst_n(rst_n), .ticks(ticks),
        .start(pace_start && (pace_control_select == PACE_TIME_A || pace_control_select == PACE_TIME_B)),
        .abort(pace_control_select == PACE_JUDGE || pace_control_select == PACE_TWO),
        .preset(pace_timer_s == '0 ? {{(TIME_W-1){1'b0}}, 1'b1} : pace_timer_s),
        .running(pace_run), .expired(pace_exp));

    ////////////////////////////////////////////////////////////////////////
    // Sequence: wait, valve close, optional reverse; a new fastening waits for idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= FTIM_IDLE;
        end else begin
            case (state_reg)
                FTIM_IDLE: begin
                    if (fastening_done) state_reg <= FTIM_WAIT;
                end
                FTIM_WAIT: begin
                    if (judge_exp) state_reg <= FTIM_VALVE;
                end
                FTIM_VALVE: begin
                    if (valve_exp) begin
                        state_reg <= (fastening_mode == FMODE_REVERSE) ? FTIM_REV : FTIM_IDLE;
                    end
                end
                FTIM_REV: begin
                    if (rev_exp) state_reg <= FTIM_IDLE;
                end
                default: state_reg <= FTIM_IDLE;
            endcase
        end
    end

    // Timer driven outputs; valve stays open until the close timer ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valve_on <= 1'b1;
            reverse_end <= 1'b0;
            measure_hold <= 1'b0;
            judge_out <= 1'b0;
            pace_expired <= 1'b0;
        end else begin
            if (valve_exp) valve_on <= 1'b0;
            else if (fastening_done && state_reg == FTIM_IDLE) valve_on <= 1'b1;
            reverse_end <= rev_exp;
            judge_out <= judge_exp;
            // Zero preset gives no run cycle, so no hold at all
            measure_hold <= pin_run && !pin_exp;
            pace_expired <= pace_exp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calendar: decimal fields split and range checked before loading
    logic [3:0] md_m;
    logic [6:0] md_d;
    logic [4:0] hm_h;
    logic [6:0] hm_m;
    logic cal_ok;
    always_comb begin
        md_m = 4'(month_day_in / 11'd100);
        md_d = 7'(month_day_in % 11'd100);
        hm_h = 5'(hour_min_in / 12'd100);
        hm_m = 7'(hour_min_in % 12'd100);
        cal_ok = (month_day_in >= MD_MIN) && (month_day_in <= MD_MAX) && md_m >= 4'h1 && md_m <= 4'hC
            && md_d >= 7'h01 && md_d <= 7'h1F && hour_min_in <= HM_MAX && hm_h <= 5'h17 && hm_m <= 7'h3B;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_year <= YEAR_BASE;
            cal_month <= 4'h1;
            cal_day <= 5'h01;
            cal_hour <= 5'h00;
            cal_minute <= 6'h00;
            cal_refused <= 1'b0;
        end else if (cal_load) begin
            cal_refused <= !cal_ok;
            if (cal_ok) begin
                cal_year <= YEAR_BASE + {4'h0, year_in};
                cal_month <= md_m;
                cal_day <= 5'(md_d);
                cal_hour <= hm_h;
                cal_minute <= 6'(hm_m);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Map check: legal codes only, no code on two terminals
    function automatic logic map_bad(input logic [CODE_W*NUM_IN-1:0] m);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < NUM_IN; i++) begin
            if (m[i*CODE_W +: CODE_W] == '0 || m[i*CODE_W +: CODE_W] > FN_STOP) bad = 1'b1;
            for (int j = i + 1; j < NUM_IN; j++) begin
                if (m[i*CODE_W +: CODE_W] == m[j*CODE_W +: CODE_W]) bad = 1'b1;
            end
        end
        return bad;
    endfunction
    logic [CODE_W*NUM_IN-1:0] in_map_reg;
    logic [CODE_W*NUM_OUT-1:0] out_map_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_map_reg <= IN_MAP_DEF;
            out_map_reg <= OUT_MAP_DEF;
            map_refused <= 1'b0;
        end else if (map_load) begin
            map_refused <= map_bad(in_map) || map_bad_out(out_map);
            if (!map_bad(in_map) && !map_bad_out(out_map)) begin
                in_map_reg <= in_map;
                out_map_reg <= out_map;
            end
        end
    end
    function automatic logic map_bad_out(input logic [CODE_W*NUM_OUT-1:0] m);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < NUM_OUT; i++) begin
            if (m[i*CODE_W +: CODE_W] == '0 || m[i*CODE_W +: CODE_W] >= 5'(NUM_OFN)) bad = 1'b1;
            for (int j = i + 1; j < NUM_OUT; j++) begin
                if (m[i*CODE_W +: CODE_W] == m[j*CODE_W +: CODE_W]) bad = 1'b1;
            end
        end
        return bad;
    endfunction

    // Pin synchronisers: three stages, change taken when stages two and three agree
    logic [NUM_IN-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            pin_reg <= '0;
        end else begin
            s1_reg <= in_pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < NUM_IN; i++) begin
                if (s2_reg[i] == s3_reg[i]) pin_reg[i] <= s3_reg[i];
            end
        end
    end

    // Route terminals to function lines; extra slot catches nothing
    logic [NUM_FN-1:0] fn_lvl, fn_prev_reg, fn_rise;
    always_comb begin
        fn_lvl = '0;
        for (int i = 0; i < NUM_IN; i++) begin
            fn_lvl[in_map_reg[i*CODE_W +: 4]] = fn_lvl[in_map_reg[i*CODE_W +: 4]] | pin_reg[i];
        end
        fn_lvl[0] = 1'b0;
        fn_rise = fn_lvl & ~fn_prev_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Function actions
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fn_prev_reg <= '0;
            judge_trigger <= 1'b0;
            process_start <= 1'b0;
            ext_start <= 1'b0;
            error_clear <= 1'b0;
            force_count_good <= 1'b0;
            tool_stop <= 1'b0;
            program_no <= 3'h0;
            remaining <= REMAIN_DEF;
        end else begin
            fn_prev_reg <= fn_lvl;
            judge_trigger <= (fn_rise[FN_JUDGE1[3:0]] && pace_control_select == PACE_JUDGE)
                || (fn_rise[FN_JUDGE2[3:0]] && pace_control_select == PACE_TWO);
            process_start <= fn_rise[FN_JUDGE1[3:0]]
                && (pace_control_select == PACE_TWO || pace_control_select == PACE_TIME_A);
            ext_start <= fn_lvl[FN_START[3:0]];
            error_clear <= fn_rise[FN_RESET[3:0]] && error_active;
            force_count_good <= fn_rise[FN_FORCE[3:0]];
            tool_stop <= fn_lvl[FN_STOP[3:0]];
            // Reset during error does not reload the count; a reload outside an error wins over a click
            if (fn_rise[FN_RESET[3:0]] && !error_active) remaining <= fastener_total;
            else if (fn_rise[FN_CLICK[3:0]] && remaining != 16'h0000) remaining <= remaining - 16'h0001;
            if (!program_select_scheme) begin
                program_no <= fn_lvl[FN_PROG_A[3:0] +: 3];
            end else begin
                program_no <= 3'h0;
                for (int k = 4; k >= 0; k--) begin
                    if (fn_lvl[FN_PROG_1[3:0] + k]) program_no <= 3'(k + 1);
                end
            end
        end
    end

    // Output terminals pick one function each
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_pins <= '0;
        end else begin
            for (int i = 0; i < NUM_OUT; i++) begin
                out_pins[i] <= out_functions[out_map_reg[i*CODE_W +: CODE_W]];
            end
        end
    end
endmodule
`default_nettype wire

// [ftim_plant.sv]
// Plant switch model: drives terminal levels as a PLC would
`timescale 1ns/1ps
`default_nettype none
module ftim_plant (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] press,
    output logic [4:0] in_pins
);
    // Contacts settle on the clock edge after a press request; released contacts read low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_pins <= 5'h00;
        end else begin
            in_pins <= press;
        end
    end
endmodule
`default_nettype wire

// [ftim_core_monitor.sv]
// Checker: timing and range relations at the top module's ports
`timescale 1ns/1ps
`default_nettype none
module ftim_core_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [13:0] pin_align_ms,
    input wire logic [3:0] fastening_mode,
    input wire logic [1:0] pace_control_select,
    input wire logic torque_judged,
    input wire logic valve_on,
    input wire logic reverse_end,
    input wire logic measure_hold,
    input wire logic judge_out,
    input wire logic pace_expired,
    input wire logic force_count_good,
    input wire logic [11:0] cal_year,
    input wire logic [3:0] cal_month,
    input wire logic [4:0] cal_day,
    input wire logic [4:0] cal_hour,
    input wire logic [5:0] cal_minute
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    //////////////////////////////////////////////////////////////////
    // Single-cycle pulse shape used by the force count-good check
    sequence s_low_next;
        ##1 1'b1 ##0 1'b1;
    endsequence
    sequence s_hold_seen;
        ##[1:4] measure_hold;
    endsequence
    chk_judge_pulse_once: assert property (judge_out |=> !judge_out)
        else $error("judge_out longer than one cycle");
    chk_rev_pulse_once: assert property (reverse_end |=> !reverse_end)
        else $error("reverse_end longer than one cycle");
    chk_rev_mode_only: assert property (reverse_end |-> fastening_mode == 4'h9)
        else $error("reverse_end outside reverse mode");
    chk_pace_time_sel: assert property (pace_expired |-> pace_control_select[1])
        else $error("pace timer used at wrong select");
    chk_valve_at_judge: assert property (judge_out |-> valve_on)
        else $error("valve off before judgment");
    chk_pin_zero_hold: assert property ($rose(measure_hold) |-> $past(pin_align_ms) != 14'h0000)
        else $error("hold raised with zero pin time");
    chk_pin_hold_start: assert property (torque_judged && pin_align_ms != 14'h0000 |-> s_hold_seen)
        else $error("hold missing after judgment");
    chk_force_pulse_once: assert property (force_count_good |-> s_low_next ##0 !force_count_good)
        else $error("force pulse too long");
    chk_year_range: assert property (cal_year >= 12'h7D0 && cal_year <= 12'h8CF)
        else $error("year outside offset range");
    chk_date_range: assert property (cal_month inside {[1:12]} && cal_day inside {[1:31]})
        else $error("month or day out of range");
    chk_time_range: assert property (cal_hour <= 5'h17 && cal_minute <= 6'h3B)
        else $error("hour or minute out of range");
endmodule
bind ftim_core ftim_core_monitor u_mon (.clk, .rst_n, .pin_align_ms, .fastening_mode, .pace_control_select,
    .torque_judged, .valve_on, .reverse_end, .measure_hold, .judge_out, .pace_expired, .force_count_good,
    .cal_year, .cal_month, .cal_day, .cal_hour, .cal_minute);
`default_nettype wire

// [ftim_core_test.sv]
// Testbench: calendar, pin alignment and terminal mapping scenarios
`timescale 1ns/1ps
`default_nettype none
module ftim_core_test;
    import ftim_pkg::*;
    logic clk = 0, rst_n = 0, pace_start = 0, error_active = 0, cal_load = 0, map_load = 0;
    logic fastening_done = 0, torque_judged = 0, program_select_scheme = 0;
    logic [13:0] pin_align_ms = 14'h0000;
    logic [3:0] fastening_mode = 4'h0;
    logic [1:0] pace_control_select = 2'h0;
    logic [15:0] fastener_total = 16'h0003;
    logic [7:0] year_in = 8'h00;
    logic [10:0] month_day_in = 11'h065;
    logic [11:0] hour_min_in = 12'h000;
    logic [24:0] in_map = IN_MAP_DEF;
    logic [24:0] out_map = OUT_MAP_DEF;
    logic [18:0] out_functions = 19'h00000;
    logic [4:0] press = 5'h00, in_pins, out_pins;
    logic valve_on, reverse_end, measure_hold, judge_out, pace_expired, map_refused, cal_refused;
    logic judge_trigger, process_start, ext_start, error_clear, force_count_good, tool_stop;
    logic [11:0] cal_year;
    logic [3:0] cal_month;
    logic [4:0] cal_day, cal_hour;
    logic [5:0] cal_minute;
    logic [15:0] remaining;
    logic [2:0] program_no;
    int n_fail = 0, compares = 0;
    //////////////////////////////////////////////////////////////////
    // Design, plant and clock
    ftim_core dut (.clk, .rst_n, .judge_wait_ms(14'h012C), .valve_close_ms(14'h012C), .reverse_done_ms(14'h012C),
        .pin_align_ms, .pace_timer_s(14'h0064), .fastening_mode, .pace_control_select, .program_select_scheme,
        .fastening_done, .torque_judged, .pace_start, .error_active, .fastener_total, .year_in, .month_day_in,
        .hour_min_in, .cal_load, .in_map, .map_load, .in_pins, .out_map, .out_functions, .out_pins,
        .valve_on, .reverse_end, .measure_hold, .judge_out, .pace_expired, .map_refused, .cal_refused, .cal_year,
        .cal_month, .cal_day, .cal_hour, .cal_minute, .judge_trigger, .process_start, .ext_start, .error_clear,
        .force_count_good, .remaining, .program_no, .tool_stop);
    ftim_plant u_plant (.clk, .rst_n, .press, .in_pins);
    initial forever #50 clk = ~clk;
    //////////////////////////////////////////////////////////////////
    // Access and compare tasks
    function automatic logic obs(input int k);
        case (k)
            0: return judge_trigger;
            1: return process_start;
            2: return ext_start;
            3: return error_clear;
            4: return force_count_good;
            5: return tool_stop;
            default: return measure_hold;
        endcase
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Press one terminal and watch for the mapped function within a bounded window
    task automatic hit(input int t, input int k, input logic exp);
        logic seen;
        seen = 1'b0;
        @(posedge clk) press[t] <= 1'b1;
        repeat (12) begin
            @(negedge clk);
            if (obs(k) === 1'b1) seen = 1'b1;
        end
        chk({15'h0, seen}, {15'h0, exp});
        @(posedge clk) press[t] <= 1'b0;
        tick(8);
    endtask
    task automatic ld_map(input logic [24:0] m);
        @(posedge clk) in_map <= m;
        map_load <= 1'b1;
        @(posedge clk) map_load <= 1'b0;
        tick(3);
    endtask
    task automatic ld_cal(input logic [7:0] y, input logic [10:0] md, input logic [11:0] hm);
        @(posedge clk) year_in <= y;
        month_day_in <= md;
        hour_min_in <= hm;
        cal_load <= 1'b1;
        @(posedge clk) cal_load <= 1'b0;
        tick(3);
    endtask
    task automatic close_out;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int i;
        tick(8);
        rst_n <= 1'b1;
        tick(2);
        chk({15'h0, valve_on}, 16'h0001);
        chk({4'h0, cal_year}, 16'h07D0);
        chk(remaining, 16'h0001);
        ld_cal(8'h06, 11'd315, 12'd1540);
        chk({cal_year, cal_month}, {12'd2006, 4'd3});
        chk({cal_day, cal_hour, cal_minute}, {5'd15, 5'd15, 6'd40});
        ld_cal(8'hFF, 11'd1231, 12'd2359);
        chk({cal_year, cal_month}, {12'd2255, 4'd12});
        chk({cal_day, cal_hour, cal_minute}, {5'd31, 5'd23, 6'd59});
        ld_cal(8'h01, 11'd1232, 12'd0000);
        chk({cal_refused, cal_year[2:0], cal_day}, {1'b1, 3'd7, 5'd31});
        $display("calendar test done");
        hit(0, 0, 1'b1);
        hit(1, 2, 1'b1);
        pace_control_select <= 2'h1;
        hit(0, 1, 1'b1);
        ld_map({5'h0F, 5'h06, 5'h05, 5'h04, 5'h03});
        chk({15'h0, map_refused}, 16'h0000);
        hit(1, 0, 1'b1);
        error_active <= 1'b1;
        hit(0, 3, 1'b1);
        chk(remaining, 16'h0001);
        error_active <= 1'b0;
        hit(0, 3, 1'b0);
        chk(remaining, 16'h0003);
        hit(3, 6, 1'b0);
        chk(remaining, 16'h0002);
        hit(2, 4, 1'b1);
        hit(4, 5, 1'b1);
        ld_map({5'h0F, 5'h06, 5'h05, 5'h01, 5'h01});
        chk({15'h0, map_refused}, 16'h0001);
        hit(4, 5, 1'b1);
        $display("map test done");
        ld_map({5'h02, 5'h01, 5'h09, 5'h08, 5'h07});
        @(posedge clk) press <= 5'h05;
        tick(10);
        chk({13'h0, program_no}, 16'h0005);
        @(posedge clk) press <= 5'h00;
        program_select_scheme <= 1'b1;
        ld_map({5'h0E, 5'h0D, 5'h0C, 5'h0B, 5'h0A});
        @(posedge clk) press <= 5'h04;
        tick(10);
        chk({13'h0, program_no}, 16'h0003);
        @(posedge clk) press <= 5'h00;
        // Remap outputs so that terminal 0 carries function 3
        out_map <= {5'h05, 5'h04, 5'h01, 5'h02, 5'h03};
        ld_map({5'h0E, 5'h0D, 5'h0C, 5'h0B, 5'h0A});
        chk({15'h0, map_refused}, 16'h0000);
        out_functions <= 19'h00008;
        tick(4);
        chk({11'h0, out_pins}, 16'h0001);
        $display("program and output test done");
        @(posedge clk) torque_judged <= 1'b1;
        @(posedge clk) torque_judged <= 1'b0;
        tick(6);
        chk({15'h0, measure_hold}, 16'h0000);
        @(posedge clk) pin_align_ms <= 14'h0001;
        torque_judged <= 1'b1;
        @(posedge clk) torque_judged <= 1'b0;
        tick(4);
        chk({15'h0, measure_hold}, 16'h0001);
        i = 0;
        while (measure_hold === 1'b1 && i < 30000) begin
            tick(1);
            i++;
        end
        chk({15'h0, measure_hold}, 16'h0000);
        chk({15'h0, (i > 9000)}, 16'h0001);
        $display("pin alignment test done");
        close_out();
    end
endmodule
`default_nettype wire
